// ===== verilog/biexec_regs.vh
// constants for the jump and increment execution block
`ifndef BIEXEC_REGS_VH
`define BIEXEC_REGS_VH
// opcode fields
`define BIEXEC_OP_INC_FILE 6'h0A
`define BIEXEC_OP_INC_SKIP 6'h0F
`define BIEXEC_OP_JUMP 3'h5
`define BIEXEC_DEST_BIT 7
`define BIEXEC_ZERO 8'h00
`define BIEXEC_ONE 8'h01
// pc high latch bits feeding pc<12:11>
`define BIEXEC_LATCH_HI 4
`define BIEXEC_LATCH_LO 3
// pc reset value
`define BIEXEC_PC_RESET 13'h0000
`endif

// ===== verilog/biexec_core.v
// execution of absolute jump, increment and increment-skip-on-zero
`timescale 1ns/10ps
`default_nettype none
`include "biexec_regs.vh"

// Functional notes
// - increment opcode adds one to file register and updates zero flag
// - destination bit clear: result goes to accumulator, file unchanged
// - destination bit set: result written back to file register
// - skip variant increments alike but leaves all status flags alone
// - skip variant with zero result flushes prefetched instruction as nop
// - skip variant takes one cycle, two when skipping; increment one
// - jump loads pc<10:0> from literal, pc<12:11> from latch<4:3>; two cycles
module biexec_core
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // instruction fetch
    input wire [13:0] instr,
    input wire instr_valid,
    // program counter
    input wire [7:0] pc_high_latch,
    output reg [12:0] pc,
    // file register port
    output wire [6:0] file_addr,
    input wire [7:0] file_rdata,
    output reg file_we,
    output reg [6:0] file_waddr,
    output reg [7:0] file_wdata,
    // accumulator and status
    output reg [7:0] acc,
    output reg zero_flag,
    output reg flush,
    output wire busy
);

// ----------------------------------------
// decode
// ----------------------------------------
// true for the plain increment pattern
function is_inc_file;
    input [13:0] op;
    begin
        is_inc_file = (op[13:8] == `BIEXEC_OP_INC_FILE);
    end
endfunction

// true for the increment that skips on a zero result
function is_inc_skip;
    input [13:0] op;
    begin
        is_inc_skip = (op[13:8] == `BIEXEC_OP_INC_SKIP);
    end
endfunction

// true for the absolute jump
function is_jump;
    input [13:0] op;
    begin
        is_jump = (op[13:11] == `BIEXEC_OP_JUMP);
    end
endfunction

// true for an all-zero result
function is_zero;
    input [7:0] val;
    begin
        is_zero = (val == `BIEXEC_ZERO);
    end
endfunction

reg flushing;
reg [12:0] next_pc;
reg [7:0] next_acc;
reg next_zero_flag;
reg next_file_we;
reg [6:0] next_file_waddr;
reg [7:0] next_file_wdata;
reg next_flush;
reg next_flushing;
wire take;
wire do_jump;
wire do_inc_file;
wire do_inc_skip;
wire inc_any;
wire dest_file;
wire inc_zero;
wire skip_taken;
wire [7:0] inc_val;
wire [12:0] jump_target;

// ----------------------------------------
// datapath
// ----------------------------------------
// a flushed slot executes as nop
assign take = instr_valid && !flushing;
assign busy = flushing;
assign file_addr = instr[6:0];
assign dest_file = instr[`BIEXEC_DEST_BIT];
assign do_jump = take && is_jump(instr);
assign do_inc_file = take && is_inc_file(instr);
assign do_inc_skip = take && is_inc_skip(instr);
assign inc_any = do_inc_file || do_inc_skip;
assign inc_val = file_rdata + `BIEXEC_ONE;
assign inc_zero = is_zero(inc_val);
assign skip_taken = do_inc_skip && inc_zero;
assign jump_target = {pc_high_latch[`BIEXEC_LATCH_HI:`BIEXEC_LATCH_LO],
                      instr[10:0]};

// ----------------------------------------
// program counter
// ----------------------------------------
always @*
begin
    next_pc = pc;
    if (do_jump)
        next_pc = jump_target;
    else if (take)
        next_pc = pc + 13'h0001;
end

// ----------------------------------------
// accumulator and zero flag
// ----------------------------------------
always @*
begin
    next_acc = acc;
    next_zero_flag = zero_flag;
    if (inc_any && !dest_file)
        next_acc = inc_val;
    if (do_inc_file)
        next_zero_flag = inc_zero;
end

// ----------------------------------------
// file write port
// ----------------------------------------
always @*
begin
    next_file_we = 1'b0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    if (inc_any && dest_file)
    begin
        next_file_we = 1'b1;
        next_file_waddr = instr[6:0];
        next_file_wdata = inc_val;
    end
end

// ----------------------------------------
// prefetch discard
// ----------------------------------------
always @*
begin
    next_flush = 1'b0;
    next_flushing = flushing;
    // a valid slot ends a pending discard
    if (instr_valid)
        next_flushing = 1'b0;
    // jump or taken skip costs a second cycle
    if (do_jump || skip_taken)
    begin
        next_flush = 1'b1;
        next_flushing = 1'b1;
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        pc <= `BIEXEC_PC_RESET;
        acc <= `BIEXEC_ZERO;
        zero_flag <= 1'b0;
        file_we <= 1'b0;
        file_waddr <= 7'h00;
        file_wdata <= `BIEXEC_ZERO;
        flush <= 1'b0;
        flushing <= 1'b0;
    end
    else
    begin
        pc <= next_pc;
        acc <= next_acc;
        zero_flag <= next_zero_flag;
        file_we <= next_file_we;
        file_waddr <= next_file_waddr;
        file_wdata <= next_file_wdata;
        flush <= next_flush;
        flushing <= next_flushing;
    end
end

endmodule // biexec_core
`default_nettype wire

// ===== test/biexec_props.sv
// checker for the jump and increment block
`timescale 1ns/10ps
`default_nettype none
module biexec_props (input wire logic clk, nrst, instr_valid, busy, file_we,
    zero_flag, flush, input wire logic [13:0] instr, input wire logic [7:0]
    file_rdata, file_wdata, acc, pc_high_latch, input wire logic [12:0] pc);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire t = instr_valid && !busy;
    wire z = file_rdata == 8'hff;
    wire i = t && instr[13:8] == 6'h0a;
    wire s = t && instr[13:8] == 6'h0f;
    wire j = t && instr[13:11] == 3'h5;
    wire [7:0] n = file_rdata + 8'h01;
    wire [12:0] g = {pc_high_latch[4:3], instr[10:0]};
    sequence s_skip; flush && busy ##1 !flush; endsequence
    a_inc_file: assert property (i && instr[7] |=>
        file_we && file_wdata == $past(n)) else $error("inc to file");
    a_inc_acc: assert property (i && !instr[7] |=>
        !file_we && acc == $past(n)) else $error("inc to acc");
    a_inc_zero: assert property (i |=>
        zero_flag == $past(z) && !flush) else $error("inc zero");
    a_skz_keep: assert property (s |=>
        $stable(zero_flag)) else $error("skip flag");
    a_skz_skip: assert property (s && z |=>
        s_skip) else $error("skip taken");
    a_skz_plain: assert property (s && !z |=>
        !flush && !busy) else $error("no skip");
    a_jump_pc: assert property (j |=>
        pc == $past(g) && busy && !file_we) else $error("jump pc");
    a_jump_keep: assert property (j |=>
        $stable(zero_flag) && $stable(acc)) else $error("jump flags");
endmodule // biexec_props
bind biexec_core biexec_props u_props (.clk, .nrst, .instr_valid, .busy,
    .file_we, .zero_flag, .flush, .instr, .file_rdata, .file_wdata, .acc,
    .pc_high_latch, .pc);
`default_nettype wire

// ===== test/branch_increment_instr_exec_bench.sv
// bench for the jump and increment block
`timescale 1ns/10ps
`default_nettype none
module branch_increment_instr_exec_bench;
    logic clk = 0, nrst = 0, instr_valid = 0, ez = 0, ef = 0;
    logic file_we, zero_flag, flush, busy;
    logic [13:0] instr = 0;
    logic [14:0] q[$];
    logic [6:0] file_addr, file_waddr;
    logic [7:0] pc_high_latch = 0, file_rdata = 0, ea, file_wdata, acc;
    logic [12:0] pc, ep = 0;
    logic [1:0] k = 0;
    logic [31:0] v = 32'hf829;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    biexec_core u_biexec_core (.clk, .nrst, .instr, .instr_valid, .pc,
        .pc_high_latch, .file_addr, .file_rdata, .file_we, .file_waddr,
        .file_wdata, .acc, .zero_flag, .flush, .busy);
    function logic [31:0] nx(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]}; endfunction
    task chk(string m, logic [15:0] e, g);
        n_checks++;
        fail_count += e !== g;
        if (e !== g) $display("BAD %s exp %h got %h", m, e, g);
    endtask
    task tally_and_finish;
        fail_count += cyc > 3000;
        $display("checks %0d bad %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 3000) tally_and_finish;
    always @(negedge clk) if (file_we)
        chk("write", q.size() ? q.pop_front() : 'x,
            {file_waddr, file_wdata});
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk) nrst = 1;
        repeat (400)
        begin
            @(negedge clk) chk("zero", ez, zero_flag);
            chk("pc", ep, pc);
            chk("flush", ef, flush);
            chk("busy", ef, busy);
            chk("addr", instr[6:0], file_addr);
            if (k == 1) chk("acc", ea, acc);
            v = nx(v);
            pc_high_latch = v[23:16];
            file_rdata = v[4:3] ? v[15:8] : 8'hff;
            ea = file_rdata + 8'h01;
            instr = v[1:0] == 2 ? {3'h5, v[26:16]}
                : {v[0] ? 6'h0f : 6'h0a, v[30:23]};
            instr_valid = 1;
            k = busy ? 0 : v[1:0] == 2 ? 2 : !v[30];
            ef = !busy && (v[1:0] == 2 || v[0] && ea == 0);
            if (!busy)
                ep = v[1:0] == 2 ? {v[20:19], v[26:16]} : ep + 13'h0001;
            if (!busy && v[1:0] != 2 && v[30])
                q.push_back({instr[6:0], ea});
            if (!busy && v[1:0] == 0) ez = ea == 0;
        end
        tally_and_finish;
    end
endmodule // branch_increment_instr_exec_bench
`default_nettype wire
